// *** shared/flyby_sdram_pkg.sv ***
// Purpose: Shared constants, types and helpers for the SDRAM and fly-by port
// Assumes: 40 MHz system clock, 32-bit external address
// Notes:   Output levels named *_n are active low
package flyby_sdram_pkg;
	// ==========================================================
	// Address map and sizes
	localparam int          ADDR_W       = 32;
	localparam int          NCH          = 4;
	localparam int          CH_W         = 2;
	localparam int          FIFO_DEPTH   = 32;
	localparam int          REGION_LSB   = 30;
	localparam logic [1:0]  SDRAM_REGION = 2'h1;
	localparam int          RSVD_LSB     = 28;
	localparam logic [1:0]  RSVD_CLEAR   = 2'h0;
	localparam int          BANK_LSB     = 26;
	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_NS = 25;
	localparam int          REFRESH_NS    = 15600;
	localparam int          REFRESH_CYC   = REFRESH_NS / CLK_PERIOD_NS;
	localparam int          REF_W         = $clog2(REFRESH_CYC + 1);
	// ==========================================================
	// Types
	typedef struct packed {
		logic              flyby;
		logic              wr;
		logic [ADDR_W-1:0] addr;
	} xfer_t;
	localparam int XFER_W = $bits(xfer_t);

	typedef enum logic [9:0] {
		ST_IDLE   = 10'h001,
		ST_ACT    = 10'h002,
		ST_RW     = 10'h004,
		ST_DATA   = 10'h008,
		ST_XFER   = 10'h010,
		ST_PRE    = 10'h020,
		ST_REF    = 10'h040,
		ST_SELF   = 10'h080,
		ST_HOSTED = 10'h100,
		ST_SUSP   = 10'h200
	} st_t;

	typedef struct packed {
		st_t              st;
		xfer_t            cur;
		xfer_t            hold;
		logic             hold_v;
		logic             req_ready;
		logic [NCH-1:0]   dmar_s1;
		logic [NCH-1:0]   dmar_s2;
		logic [NCH-1:0]   dmar_d;
		logic [NCH-1:0]   pend;
		logic             hbr_s1;
		logic             hbr_s2;
		logic [REF_W-1:0] ref_cnt;
		logic             ref_due;
		logic [NCH-1:0]   bs_n;
		logic             ras_n;
		logic             cas_n;
		logic             we_n;
		logic             dqm;
		logic             a10;
		logic             cke;
		logic             ctl_oe;
		logic             addr_oe;
		logic             flyby_io_write_strobe_n;
		logic             flyby_io_read_strobe_n;
		logic             flyby_io_output_enable_n;
		logic             hbg_n;
		logic             done;
	} top_state_t;

	localparam top_state_t RESET_STATE = '{
		st: ST_IDLE, ref_cnt: REF_W'(REFRESH_CYC), bs_n: 4'hF, ras_n: 1'b1, cas_n: 1'b1,
		we_n: 1'b1, dqm: 1'b1, cke: 1'b1, flyby_io_write_strobe_n: 1'b1, flyby_io_read_strobe_n: 1'b1, flyby_io_output_enable_n: 1'b1,
		hbg_n: 1'b1, req_ready: 1'b1, default: '0};

	// ==========================================================
	// Helpers
	function automatic logic sdram_hit(input logic [ADDR_W-1:0] a);
		return a[REGION_LSB+:2] == SDRAM_REGION && a[RSVD_LSB+:2] == RSVD_CLEAR;
	endfunction

	function automatic logic [NCH-1:0] bank_sel(input logic [ADDR_W-1:0] a);
		return NCH'(1) << a[BANK_LSB+:CH_W];
	endfunction

	function automatic logic [CH_W-1:0] lowest(input logic [NCH-1:0] v);
		logic [CH_W-1:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--)
			if (v[i])
				r = CH_W'(i);
		return r;
	endfunction
endpackage

// *** shared/xfer_fifo_if.sv ***
// Purpose: Valid/ready carrier between the request mux and the queue
// Assumes: One clock for both sides
// Notes:   Data is one packed transfer descriptor
`timescale 1ns/1ps
`default_nettype none
interface xfer_fifo_if #(parameter int W = 34);
	logic [W-1:0] in_data;
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] out_data;
	logic         out_valid;
	logic         out_ready;
	modport queue (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
	modport user  (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface
`default_nettype wire

// *** rtl/xfer_fifo.sv ***
// Purpose: Transfer queue between request capture and the SDRAM sequencer
// Assumes: Synchronous, single clock, clock enable freezes all state
// Notes:   in_ready is registered so it can be used directly by the source
`timescale 1ns/1ps
`default_nettype none
module xfer_fifo
	import flyby_sdram_pkg::*;
#(
	parameter int W     = XFER_W,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic  clk_i,
	input  wire logic  arst_n_i,
	input  wire logic  ce_i,
	xfer_fifo_if.queue q
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           rd;
		logic [PW-1:0]           wr;
		logic [PW:0]             count;
		logic                    room;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t next_s;
	logic        push;
	logic        pop;

	assign q.in_ready  = s.room;
	assign q.out_valid = s.count != '0;
	assign q.out_data  = s.mem[s.rd];

	always_comb
	begin
		next_s = s;
		push   = q.in_valid && s.room;
		pop    = q.out_ready && (s.count != '0);
		if (push)
		begin
			next_s.mem[s.wr] = q.in_data;
			next_s.wr        = s.wr + PW'(1);
		end
		if (pop)
			next_s.rd = s.rd + PW'(1);
		next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
		next_s.room  = next_s.count != (PW+1)'(DEPTH);
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			s <= '{room: 1'b1, default: '0};
		else if (ce_i)
			s <= next_s;
	end
endmodule
`default_nettype wire

// *** rtl/flyby_sdram_port.sv ***
// Purpose: SDRAM command pins and fly-by DMA strobes of the external port
// Assumes: Bus mastership decided elsewhere; data bus handled elsewhere
// Notes:   Only the lowest pending DMA channel is queued per cycle
//
// Functional notes
// - A falling DMA request line queues one transfer set by that channel's setup.
// - Requests on channels not marked initialized are ignored.
// - Fly-by memory reads hold the I/O write strobe low over the data cycles.
// - Fly-by memory writes drop the I/O read strobe in the data cycle with output enable.
// - The I/O output enable goes low only during fly-by transfers.
// - Every SDRAM command cycle to the 01 region drives a bank select low.
// - Only the bus master drives the SDRAM control outputs.
// - Row strobe low marks the row address and encodes other commands.
// - Column strobe low marks the column address and encodes other commands.
// - With column strobe low, write enable is low for writes and high for reads.
// - The data mask is high when idle, valid with column strobe, low on reads.
// - Address bit 10 has its own pin so refresh leaves the shared bus free.
// - The clock enable output enters and leaves self-refresh and suspend.
// - Before granting the bus to a host, SDRAM enters self-refresh and pins float.
`timescale 1ns/1ps
`default_nettype none
module flyby_sdram_port
	import flyby_sdram_pkg::*;
(
	input  wire logic                   SYS_CLK_I,
	input  wire logic                   ARST_N_I,
	input  wire logic                   CLK_EN_I,
	input  wire logic [NCH-1:0]         DMA_REQUEST_IN_N_I,
	input  wire logic [NCH-1:0]         CHAN_INIT_I,
	input  wire logic [NCH-1:0]         CHAN_FLYBY_WRITE_I,
	input  wire logic [NCH-1:0][ADDR_W-1:0] CHAN_ADDR_I,
	input  wire logic                   REQ_VALID_I,
	input  wire logic                   REQ_WRITE_I,
	input  wire logic [ADDR_W-1:0]      REQ_ADDR_I,
	input  wire logic                   BUS_MASTER_I,
	input  wire logic                   HOST_BUS_REQUEST_N_I,
	input  wire logic                   SUSPEND_I,
	output logic                        REQ_READY_O,
	output logic                        DONE_O,
	output logic [NCH-1:0]              SDRAM_BANK_SELECT_N_O,
	output logic                        ROW_STROBE_N_O,
	output logic                        COL_STROBE_N_O,
	output logic                        SDRAM_WRITE_ENABLE_N_O,
	output logic                        LOW_WORD_DATA_MASK_O,
	output logic                        SDRAM_ADDR_BIT10_O,
	output logic                        SDRAM_CLOCK_ENABLE_O,
	output logic                        SDRAM_CTRL_OE_O,
	output logic [ADDR_W-1:0]           EXTERNAL_ADDRESS_BUS_O,
	output logic                        ADDR_OE_O,
	output logic                        FLYBY_IO_WRITE_STROBE_N_O,
	output logic                        FLYBY_IO_READ_STROBE_N_O,
	output logic                        FLYBY_IO_OUTPUT_ENABLE_N_O,
	output logic                        HOST_BUS_GRANT_N_O
);
	// ==========================================================
	// State and queue
	top_state_t      s;
	top_state_t      next_s;
	logic [NCH-1:0]  rise;
	logic [CH_W-1:0] idx;
	logic [NCH-1:0]  taken;
	logic            ref_set;
	logic            ref_clr;

	xfer_fifo_if #(.W(XFER_W)) q ();

	xfer_fifo #(
		.W     (XFER_W),
		.DEPTH (FIFO_DEPTH)
	) u_queue (
		.clk_i    (SYS_CLK_I),
		.arst_n_i (ARST_N_I),
		.ce_i     (CLK_EN_I),
		.q        (q)
	);

	// ==========================================================
	// Outputs straight from state
	assign REQ_READY_O                = s.req_ready;
	assign DONE_O                     = s.done;
	assign SDRAM_BANK_SELECT_N_O      = s.bs_n;
	assign ROW_STROBE_N_O             = s.ras_n;
	assign COL_STROBE_N_O             = s.cas_n;
	assign SDRAM_WRITE_ENABLE_N_O     = s.we_n;
	assign LOW_WORD_DATA_MASK_O       = s.dqm;
	assign SDRAM_ADDR_BIT10_O         = s.a10;
	assign SDRAM_CLOCK_ENABLE_O       = s.cke;
	assign SDRAM_CTRL_OE_O            = s.ctl_oe;
	assign EXTERNAL_ADDRESS_BUS_O     = s.cur.addr;
	assign ADDR_OE_O                  = s.addr_oe;
	assign FLYBY_IO_WRITE_STROBE_N_O  = s.flyby_io_write_strobe_n;
	assign FLYBY_IO_READ_STROBE_N_O   = s.flyby_io_read_strobe_n;
	assign FLYBY_IO_OUTPUT_ENABLE_N_O = s.flyby_io_output_enable_n;
	assign HOST_BUS_GRANT_N_O         = s.hbg_n;

	always_comb
	begin
		next_s      = s;
		next_s.done = 1'b0;
		q.in_valid  = 1'b0;
		q.in_data   = '0;
		q.out_ready = 1'b0;
		taken       = '0;

		// ==========================================================
		// Pin synchronisers
		next_s.dmar_s1 = ~DMA_REQUEST_IN_N_I;
		next_s.dmar_s2 = s.dmar_s1;
		next_s.dmar_d  = s.dmar_s2;
		next_s.hbr_s1  = ~HOST_BUS_REQUEST_N_I;
		next_s.hbr_s2  = s.hbr_s1;
		rise           = s.dmar_s2 & ~s.dmar_d;
		idx            = lowest(s.pend);

		// ==========================================================
		// Queue fill: DMA ahead of core requests
		if (|s.pend)
		begin
			q.in_valid = 1'b1;
			q.in_data  = {1'b1, CHAN_FLYBY_WRITE_I[idx], CHAN_ADDR_I[idx]};
			if (q.in_ready)
				taken = NCH'(1) << idx;
		end
		else if (s.hold_v)
		begin
			q.in_valid = 1'b1;
			q.in_data  = s.hold;
			if (q.in_ready)
				next_s.hold_v = 1'b0;
		end
		// New edge wins over a same-cycle hand-off
		next_s.pend = (s.pend & ~taken) | (rise & CHAN_INIT_I);

		// One-deep holding slot keeps REQ_READY_O a plain flop
		if (REQ_VALID_I && s.req_ready)
		begin
			next_s.hold   = '{flyby: 1'b0, wr: REQ_WRITE_I, addr: REQ_ADDR_I};
			next_s.hold_v = 1'b1;
		end
		next_s.req_ready = !next_s.hold_v;

		// ==========================================================
		// Refresh interval
		ref_set = s.ref_cnt == '0;
		if (ref_set)
			next_s.ref_cnt = REF_W'(REFRESH_CYC);
		else
			next_s.ref_cnt = s.ref_cnt - REF_W'(1);

		// ==========================================================
		// Sequencer
		case (s.st)
			ST_IDLE:
			begin
				if (!BUS_MASTER_I)
					next_s.st = ST_IDLE;
				else if (s.hbr_s2 || s.ref_due)
					next_s.st = ST_PRE;
				else if (SUSPEND_I)
					next_s.st = ST_SUSP;
				else if (q.out_valid)
				begin
					q.out_ready = 1'b1;
					next_s.cur  = xfer_t'(q.out_data);
					// Reserved sub-ranges go out as plain bus cycles
					next_s.st   = sdram_hit(q.out_data[ADDR_W-1:0]) ? ST_ACT : ST_XFER;
				end
			end
			ST_ACT:
				next_s.st = ST_RW;
			ST_RW:
			begin
				next_s.st   = s.cur.wr ? ST_IDLE : ST_DATA;
				next_s.done = s.cur.wr;
			end
			ST_DATA, ST_XFER:
			begin
				next_s.st   = ST_IDLE;
				next_s.done = 1'b1;
			end
			ST_PRE:
				next_s.st = s.hbr_s2 ? ST_SELF : ST_REF;
			ST_REF:
				next_s.st = ST_IDLE;
			ST_SELF:
				next_s.st = ST_HOSTED;
			ST_HOSTED:
				if (!s.hbr_s2)
					next_s.st = ST_IDLE;
			ST_SUSP:
				if (!SUSPEND_I)
					next_s.st = ST_IDLE;
			default:
				next_s.st = ST_IDLE;
		endcase

		// Self-refresh counts as a refresh; a due tick the same cycle is kept
		ref_clr        = next_s.st == ST_REF || next_s.st == ST_SELF;
		next_s.ref_due = (s.ref_due && !ref_clr) || ref_set;

		// ==========================================================
		// Pin levels for the coming state
		next_s.bs_n    = '1;
		next_s.ras_n   = 1'b1;
		next_s.cas_n   = 1'b1;
		next_s.we_n    = 1'b1;
		next_s.dqm     = 1'b1;
		next_s.a10     = 1'b0;
		next_s.cke     = 1'b1;
		next_s.addr_oe = 1'b0;
		next_s.flyby_io_write_strobe_n  = 1'b1;
		next_s.flyby_io_read_strobe_n  = 1'b1;
		next_s.flyby_io_output_enable_n  = 1'b1;
		next_s.hbg_n   = 1'b1;
		next_s.ctl_oe  = BUS_MASTER_I && next_s.st != ST_HOSTED;
		case (next_s.st)
			ST_ACT:
			begin
				next_s.bs_n    = ~bank_sel(next_s.cur.addr);
				next_s.ras_n   = 1'b0;
				next_s.addr_oe = 1'b1;
				next_s.flyby_io_output_enable_n  = !next_s.cur.flyby;
			end
			ST_RW:
			begin
				next_s.bs_n    = ~bank_sel(next_s.cur.addr);
				next_s.cas_n   = 1'b0;
				next_s.we_n    = !next_s.cur.wr;
				next_s.a10     = 1'b1;
				next_s.dqm     = 1'b0;
				next_s.addr_oe = 1'b1;
				next_s.flyby_io_output_enable_n  = !next_s.cur.flyby;
				next_s.flyby_io_write_strobe_n  = !(next_s.cur.flyby && !next_s.cur.wr);
				next_s.flyby_io_read_strobe_n  = !(next_s.cur.flyby && next_s.cur.wr);
			end
			ST_DATA:
			begin
				next_s.dqm    = 1'b0;
				next_s.flyby_io_output_enable_n = !next_s.cur.flyby;
				next_s.flyby_io_write_strobe_n = !next_s.cur.flyby;
			end
			ST_XFER:
				next_s.addr_oe = 1'b1;
			ST_PRE:
			begin
				next_s.bs_n  = '0;
				next_s.ras_n = 1'b0;
				next_s.we_n  = 1'b0;
				next_s.a10   = 1'b1;
			end
			ST_REF:
			begin
				// Shared address bus stays free during refresh
				next_s.bs_n  = '0;
				next_s.ras_n = 1'b0;
				next_s.cas_n = 1'b0;
			end
			ST_SELF:
			begin
				next_s.bs_n  = '0;
				next_s.ras_n = 1'b0;
				next_s.cas_n = 1'b0;
				next_s.cke   = 1'b0;
			end
			ST_HOSTED:
			begin
				next_s.cke   = 1'b0;
				next_s.hbg_n = 1'b0;
			end
			ST_SUSP:
				next_s.cke = 1'b0;
			default:
				next_s.cke = 1'b1;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			s <= RESET_STATE;
		else if (CLK_EN_I)
			s <= next_s;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge SYS_CLK_I iff CLK_EN_I);
	endclocking
	default disable iff (!ARST_N_I);

	property p_act_bank;
		(SDRAM_CTRL_OE_O && !ROW_STROBE_N_O && COL_STROBE_N_O && SDRAM_WRITE_ENABLE_N_O)
			|-> $onehot(~SDRAM_BANK_SELECT_N_O) && sdram_hit(EXTERNAL_ADDRESS_BUS_O)
			##1 !COL_STROBE_N_O && SDRAM_BANK_SELECT_N_O == $past(SDRAM_BANK_SELECT_N_O);
	endproperty
	a_act_bank: assert property (p_act_bank) else $error("bank select wrong on activate");

	property p_rsvd_quiet;
		(s.st == ST_XFER) |-> SDRAM_BANK_SELECT_N_O == 4'hF && ROW_STROBE_N_O;
	endproperty
	a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("bank select on non-SDRAM cycle");

	property p_flyby_read;
		$fell(FLYBY_IO_WRITE_STROBE_N_O) |-> !COL_STROBE_N_O && SDRAM_WRITE_ENABLE_N_O
			##1 !FLYBY_IO_WRITE_STROBE_N_O ##1 FLYBY_IO_WRITE_STROBE_N_O;
	endproperty
	a_flyby_read: assert property (p_flyby_read) else $error("io write strobe span wrong");

	property p_flyby_write;
		!FLYBY_IO_READ_STROBE_N_O
			|-> !COL_STROBE_N_O && !SDRAM_WRITE_ENABLE_N_O && !FLYBY_IO_OUTPUT_ENABLE_N_O;
	endproperty
	a_flyby_write: assert property (p_flyby_write) else $error("io read strobe outside write");

	property p_flyby_io_output_enable_flyby;
		$fell(FLYBY_IO_OUTPUT_ENABLE_N_O) |-> !ROW_STROBE_N_O && s.cur.flyby ##1 !COL_STROBE_N_O;
	endproperty
	a_flyby_io_output_enable_flyby: assert property (p_flyby_io_output_enable_flyby) else $error("io enable off fly-by");

	property p_we_dir;
		(!COL_STROBE_N_O && ROW_STROBE_N_O) |-> SDRAM_WRITE_ENABLE_N_O == !s.cur.wr;
	endproperty
	a_we_dir: assert property (p_we_dir) else $error("write enable direction wrong");

	property p_mask_read;
		(!COL_STROBE_N_O && ROW_STROBE_N_O && SDRAM_WRITE_ENABLE_N_O)
			|-> !LOW_WORD_DATA_MASK_O ##1 !LOW_WORD_DATA_MASK_O ##1 LOW_WORD_DATA_MASK_O;
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("data mask active on read");

	property p_refresh_bus;
		(!ROW_STROBE_N_O && !COL_STROBE_N_O) |-> !ADDR_OE_O && SDRAM_BANK_SELECT_N_O == 4'h0;
	endproperty
	a_refresh_bus: assert property (p_refresh_bus) else $error("address bus held in refresh");

	property p_host_self;
		$fell(HOST_BUS_GRANT_N_O) |-> !SDRAM_CTRL_OE_O && !SDRAM_CLOCK_ENABLE_O
			&& $past(!ROW_STROBE_N_O && !COL_STROBE_N_O && !SDRAM_CLOCK_ENABLE_O);
	endproperty
	a_host_self: assert property (p_host_self) else $error("grant without self-refresh");

	property p_slave_quiet;
		!BUS_MASTER_I |=> !SDRAM_CTRL_OE_O;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives SDRAM pins");

	property p_init_only;
		(s.pend & ~$past(s.pend) & ~$past(CHAN_INIT_I)) == 4'h0;
	endproperty
	a_init_only: assert property (p_init_only) else $error("uninitialized channel queued");
endmodule
`default_nettype wire

// *** sim/io_dma_partner.sv ***
// Purpose: External DMA I/O device facing the fly-by port
// Assumes: Request pins have a pull-up, so a released line reads high
// Notes:   Line drops on start, rises once served or after a bounded wait
`timescale 1ns/1ps
`default_nettype none
module io_dma_partner
	import flyby_sdram_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic [NCH-1:0] start_i,
	input  wire logic           flyby_io_output_enable_n_i,
	input  wire logic           flyby_io_read_strobe_n_i,
	output logic [NCH-1:0]      dmar_n_o,
	output logic                drives_o
);
	// ==========================================
	// Request lines
	logic [NCH-1:0] line_n = '1;
	logic [4:0]     wait_cnt [NCH] = '{default: '0};

	always @(posedge clk_i)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			if (start_i[i])
			begin
				line_n[i] <= 1'b0;
				wait_cnt[i] <= '0;
			end
			else if (!line_n[i])
			begin
				wait_cnt[i] <= wait_cnt[i] + 5'h01;
				// Give up so an ignored request cannot hold the line forever
				if (!flyby_io_output_enable_n_i || wait_cnt[i] == 5'h1F)
					line_n[i] <= 1'b1;
			end
		end
	end
	assign dmar_n_o = line_n;
	// Device puts data on the bus only under the fly-by read strobe and output enable
	assign drives_o = !flyby_io_read_strobe_n_i && !flyby_io_output_enable_n_i;
endmodule
`default_nettype wire

// *** sim/flyby_sdram_port_tb.sv ***
// Purpose: Self-checking bench for the SDRAM and fly-by port
// Assumes: 40 MHz clock, package refresh interval
// Notes:   Outputs are sampled on the falling edge, inputs set on the rising
`timescale 1ns/1ps
`default_nettype none
module flyby_sdram_port_tb
	import flyby_sdram_pkg::*;
;
	// ==========================================
	// Signals
	logic                       clk, arst_n, clk_en, req_valid, req_write;
	logic                       bus_master, hbr_n, suspend;
	logic [ADDR_W-1:0]          req_addr;
	logic [NCH-1:0]             chan_init, chan_fw, start;
	logic [NCH-1:0][ADDR_W-1:0] chan_addr;
	wire logic [NCH-1:0]        dmar_n;
	wire logic                  drives;
	logic                       ready, done, row_n, col_n, we_n, mask, a10, cke;
	logic                       ctl_oe, aoe, flyby_io_write_strobe_n, flyby_io_read_strobe_n, flyby_io_output_enable_n, grant_n;
	logic [NCH-1:0]             bs_n;
	logic [ADDR_W-1:0]          ext_addr;
	int                         num_errors, tests_run, dones, acts, flys;

	flyby_sdram_port u_dut (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .CLK_EN_I(clk_en),
		.DMA_REQUEST_IN_N_I(dmar_n), .CHAN_INIT_I(chan_init), .CHAN_FLYBY_WRITE_I(chan_fw),
		.CHAN_ADDR_I(chan_addr), .REQ_VALID_I(req_valid), .REQ_WRITE_I(req_write),
		.REQ_ADDR_I(req_addr), .BUS_MASTER_I(bus_master), .HOST_BUS_REQUEST_N_I(hbr_n),
		.SUSPEND_I(suspend), .REQ_READY_O(ready), .DONE_O(done),
		.SDRAM_BANK_SELECT_N_O(bs_n), .ROW_STROBE_N_O(row_n), .COL_STROBE_N_O(col_n),
		.SDRAM_WRITE_ENABLE_N_O(we_n), .LOW_WORD_DATA_MASK_O(mask),
		.SDRAM_ADDR_BIT10_O(a10), .SDRAM_CLOCK_ENABLE_O(cke), .SDRAM_CTRL_OE_O(ctl_oe),
		.EXTERNAL_ADDRESS_BUS_O(ext_addr), .ADDR_OE_O(aoe),
		.FLYBY_IO_WRITE_STROBE_N_O(flyby_io_write_strobe_n), .FLYBY_IO_READ_STROBE_N_O(flyby_io_read_strobe_n),
		.FLYBY_IO_OUTPUT_ENABLE_N_O(flyby_io_output_enable_n), .HOST_BUS_GRANT_N_O(grant_n));

	io_dma_partner u_dev (.clk_i(clk), .start_i(start), .flyby_io_output_enable_n_i(flyby_io_output_enable_n),
		.flyby_io_read_strobe_n_i(flyby_io_read_strobe_n), .dmar_n_o(dmar_n), .drives_o(drives));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Activates counted as row low with column and write high
	always @(posedge clk)
	begin
		if (done === 1'b1) dones++;
		if (row_n === 1'b0 && col_n === 1'b1 && we_n === 1'b1) acts++;
		if (flyby_io_output_enable_n === 1'b0) flys++;
	end

	// ==========================================
	// Shared tasks
	task automatic chk(input logic c, input string m);
		tests_run++;
		if (!c)
		begin
			num_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic send(input logic w, input logic [ADDR_W-1:0] a, output int waits);
		waits = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		@(negedge clk);
		while (ready !== 1'b1 && waits < 200)
		begin
			waits++;
			@(negedge clk);
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask

	// fly: 0 plain, 1 fly-by memory read, 2 fly-by memory write
	task automatic walk(input logic w, input logic [ADDR_W-1:0] a, input int fly);
		int n;
		int d0;
		n = 0;
		d0 = dones;
		while (!(row_n === 1'b0 && col_n === 1'b1 && we_n === 1'b1) && n < 60)
		begin
			n++;
			@(negedge clk);
		end
		chk(bs_n === ~(4'h1 << a[27:26]) && aoe === 1'b1, "activate select");
		chk(ext_addr === a, "activate address");
		chk(flyby_io_output_enable_n === (fly == 0) && flyby_io_write_strobe_n === 1'b1 && flyby_io_read_strobe_n === 1'b1, "act strobes");
		@(negedge clk);
		chk(col_n === 1'b0 && we_n === !w && a10 === 1'b1 && mask === 1'b0, "column");
		chk(flyby_io_output_enable_n === (fly == 0) && flyby_io_write_strobe_n === (fly != 1) && flyby_io_read_strobe_n === (fly != 2), "col io");
		chk(drives === (fly == 2), "device drive");
		if (!w)
		begin
			@(negedge clk);
			chk(mask === 1'b0 && flyby_io_write_strobe_n === (fly != 1) && flyby_io_output_enable_n === (fly != 1), "data");
		end
		n = 0;
		while (dones == d0 && n < 10)
		begin
			n++;
			@(negedge clk);
		end
		chk(dones == d0 + 1, "no completion");
	endtask

	task automatic pulse(input int ch);
		@(posedge clk);
		start[ch] <= 1'b1;
		@(posedge clk);
		start[ch] <= 1'b0;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_core();
		int w;
		send(1'b1, 32'h4800_0104, w);
		walk(1'b1, 32'h4800_0104, 0);
		send(1'b0, 32'h4400_0200, w);
		walk(1'b0, 32'h4400_0200, 0);
	endtask

	task automatic t_reserved();
		int w;
		int a0;
		int d0;
		a0 = acts;
		d0 = dones;
		send(1'b1, 32'h5000_0000, w);
		send(1'b0, 32'h8000_0000, w);
		repeat (20) @(negedge clk);
		chk(acts == a0 && dones == d0 + 2, "reserved got select");
	endtask

	task automatic t_dma();
		int a0;
		int f0;
		a0 = acts;
		f0 = flys;
		pulse(0);
		repeat (45) @(negedge clk);
		chk(acts == a0 && flys == f0, "uninitialized served");
		pulse(2);
		walk(1'b0, chan_addr[2], 1);
		pulse(3);
		walk(1'b1, chan_addr[3], 2);
	endtask

	task automatic t_host();
		int n;
		n = 0;
		@(posedge clk);
		hbr_n <= 1'b0;
		while (grant_n !== 1'b0 && n < 60)
		begin
			n++;
			@(negedge clk);
		end
		chk(grant_n === 1'b0 && cke === 1'b0 && ctl_oe === 1'b0, "host grant");
		n = 0;
		@(posedge clk);
		hbr_n <= 1'b1;
		while (grant_n !== 1'b1 && n < 20)
		begin
			n++;
			@(negedge clk);
		end
		repeat (3) @(negedge clk);
		chk(grant_n === 1'b1 && cke === 1'b1 && ctl_oe === 1'b1, "host release");
	endtask

	task automatic t_master();
		@(posedge clk);
		bus_master <= 1'b0;
		repeat (3) @(negedge clk);
		chk(ctl_oe === 1'b0, "slave drives");
		@(posedge clk);
		bus_master <= 1'b1;
		repeat (3) @(negedge clk);
		chk(ctl_oe === 1'b1, "master floats");
	endtask

	task automatic t_suspend();
		int n;
		n = 0;
		@(posedge clk);
		suspend <= 1'b1;
		while (cke !== 1'b0 && n < 40)
		begin
			n++;
			@(negedge clk);
		end
		chk(cke === 1'b0, "no suspend");
		n = 0;
		@(posedge clk);
		suspend <= 1'b0;
		while (cke !== 1'b1 && n < 40)
		begin
			n++;
			@(negedge clk);
		end
		chk(cke === 1'b1, "no wake");
	endtask

	// Fill the queue until the slot refuses, then drain it empty
	task automatic t_fill();
		int w;
		int mx;
		int a0;
		int d0;
		int n;
		mx = 0;
		a0 = acts;
		d0 = dones;
		// Sequencer held off while sending, else the queue drains too fast to ever fill
		@(posedge clk);
		bus_master <= 1'b0;
		fork
			begin
				repeat (120) @(posedge clk);
				bus_master <= 1'b1;
			end
		join_none
		for (int i = 0; i < 40; i++)
		begin
			send(1'b1, 32'h4000_0000 + 32'(i * 4), w);
			if (w > mx) mx = w;
		end
		chk(mx > 2, "queue never refused");
		n = 0;
		while (dones < d0 + 40 && n < 1500)
		begin
			n++;
			@(negedge clk);
		end
		chk(dones == d0 + 40 && acts == a0 + 40 && ready === 1'b1, "drain");
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		num_errors = 0;
		tests_run = 0;
		dones = 0;
		acts = 0;
		flys = 0;
		arst_n = 1'b0;
		clk_en = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		bus_master = 1'b1;
		hbr_n = 1'b1;
		suspend = 1'b0;
		start = '0;
		chan_init = 4'hC;
		chan_fw = 4'h8;
		chan_addr = {32'h4C00_0020, 32'h4400_0010, 32'h4000_0030, 32'h4000_0040};
		repeat (20) @(negedge clk);
		chk(bs_n === 4'hF && mask === 1'b1 && cke === 1'b1 && ctl_oe === 1'b0, "reset");
		@(posedge clk);
		arst_n <= 1'b1;
		t_core();
		t_reserved();
		t_dma();
		t_master();
		t_suspend();
		t_host();
		t_fill();
		final_report();
	end

	// Whole run needs several hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report();
	end
endmodule
`default_nettype wire
